// ==== hw/pwsq_defines.svh ====
/*
  Register offsets, field positions, write masks and reset values of the
  power sleep/wake sequencer. Assumes inclusion by bare name from hw/.
*/
`ifndef PWSQ_DEFINES_SVH
`define PWSQ_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define PWSQ_OFS_MODE 8'h00
`define PWSQ_OFS_WAKE_LO 8'h04
`define PWSQ_OFS_WAKE_HI 8'h08
`define PWSQ_OFS_DORMANT 8'h0C
`define PWSQ_OFS_ROUSE1 8'h10
`define PWSQ_OFS_ROUSE2 8'h14
`define PWSQ_OFS_RUNNING 8'h18
`define PWSQ_OFS_SLEEP1 8'h1C
`define PWSQ_OFS_SLEEP2 8'h20
`define PWSQ_OFS_STATUS 8'h24
`define PWSQ_OFS_BUCK 8'h2C
`define PWSQ_OFS_GOOD 8'h30
`define PWSQ_OFS_CORE_LVL 8'h34
`define PWSQ_OFS_PLL_LVL 8'h40

// ----------------------------------------------------------------------------
// Mode control fields
// ----------------------------------------------------------------------------
`define PWSQ_MODE_CLKSEL 0
`define PWSQ_MODE_SLEEP 1
`define PWSQ_MODE_PIN_EN 2
`define PWSQ_MODE_PIN_POL 3
`define PWSQ_MODE_TMR_EN 4
`define PWSQ_MODE_TMR64 5
`define PWSQ_MODE_REAPPLY 6
`define PWSQ_MODE_PORLVL 7
`define PWSQ_MODE_USB_DN 8
`define PWSQ_MODE_USB_UP 9
`define PWSQ_MODE_RST 32'h0000_0008
`define PWSQ_MODE_WMASK 32'h0000_03BD

// ----------------------------------------------------------------------------
// Supply configuration fields
// ----------------------------------------------------------------------------
`define PWSQ_SUP_CORE_EN 0
`define PWSQ_SUP_ANA_EN 1
`define PWSQ_SUP_PLL_EN 4
`define PWSQ_SUP_IO_EN 5
`define PWSQ_SUP_CORE_PFM 8
`define PWSQ_SUP_ANA_PFM 9
`define PWSQ_SUP_TILE_OFF 14
`define PWSQ_SUP_LOG_LO 16
`define PWSQ_SUP_LOG_HI 20
`define PWSQ_SUP_WMASK 32'h001F_4331
`define PWSQ_RUN_WMASK 32'h0000_4331
`define PWSQ_DORMANT_RST 32'h0010_0000
`define PWSQ_ROUSE1_RST 32'h0010_0020
`define PWSQ_ROUSE2_RST 32'h0010_0033
`define PWSQ_RUNNING_RST 32'h0000_0033
`define PWSQ_SLEEP_RST 32'h0010_0033
`define PWSQ_WORD_RST 32'h0000_0000
// Supply outputs in reset: the four enables of the running word, no PFM, tile clocked
`define PWSQ_SUPPLY_RST 7'h0F

`endif

// ==== hw/pwsq_pkg.sv ====
/*
  Types of the power sleep/wake sequencer. Constants live in pwsq_defines.svh.
*/
package pwsq_pkg;

  // Sequencer states, in walking order
  typedef enum logic [2:0] {
    running_state,
    sleep_entry_stage_one,
    sleep_entry_stage_two,
    dormant_state,
    rouse_stage_one,
    rouse_stage_two
  } pwsq_state_t;

  // Supply outputs applied by the current state
  typedef struct packed {
    logic tile_clk_off;
    logic analogue_buck_converter_pfm;
    logic core_buck_converter_pfm;
    logic io_supply_switch_en;
    logic pll_supply_regulator_en;
    logic analogue_buck_converter_en;
    logic core_buck_converter_en;
  } pwsq_supply_t;

  // Whole register state of the block
  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] wake_lo;
    logic [31:0] wake_hi;
    logic [31:0] cfg_dormant;
    logic [31:0] cfg_rouse1;
    logic [31:0] cfg_rouse2;
    logic [31:0] cfg_running;
    logic [31:0] cfg_sleep1;
    logic [31:0] cfg_sleep2;
    logic [31:0] buck;
    logic [31:0] core_lvl;
    logic [31:0] pll_lvl;
    pwsq_state_t state;
    logic [31:0] dwell;
    logic [31:0] rdata;
    logic rvalid;
    pwsq_supply_t supply;
    logic slow_clk_sel;
    logic usb_pwr_dn;
    logic usb_pwr_up;
    logic use_por_levels;
  } pwsq_regs_t;

endpackage

// ==== hw/pwsq_sequencer.sv ====
/*
  Power sleep/wake sequencer: register file on the 32-bit peripheral word
  path plus the running/sleep/dormant/waking state walk.
  Assumes the real-time counter, wake pin and supply-good flags are synchronous
  to clk, and that clk is whichever clock is currently enabled.
*/
// Operation
// - Registers accessed only as whole words
// - Mode bit 1 starts sleep, self-clears
// - Mode bit 6 reapplies running supplies
// - Bit 7 picks stored or power-on levels
// - Bit 4 enables timer wake while dormant
// - Bit 5 widens comparison to 64 bits
// - Bit 2 enables wake pin while dormant
// - Bit 3 selects pin active level
// - Bit 0 selects dormant clock, dormant only
// - Bits 8,9 steer USB suspend controller
// - Dormant lasts at least 2^field cycles
// - After minimum, leave only on wake
// - Dwell counted in current clock cycles
// - Bit 14 gates tile clock
// - Bits 9,8 select converter modulation
// - Bits 5,4,0 enable supplies
// - Analogue converter enable bit read-only
// - Waking stage waits time and supplies good
`timescale 1ns/1ps
`default_nettype none
`include "pwsq_defines.svh"

module pwsq_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Peripheral word access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Wake sources
  input wire logic [63:0] rtc_count,
  input wire logic wake_pin,
  // Supply good flags: io, pll, analogue, core
  input wire logic [3:0] supply_good,
  // Supply and clock controls
  output logic core_buck_converter_en,
  output logic analogue_buck_converter_en,
  output logic pll_supply_regulator_en,
  output logic io_supply_switch_en,
  output logic core_buck_converter_pfm,
  output logic analogue_buck_converter_pfm,
  output logic tile_clk_off,
  output logic slow_clk_sel,
  // USB suspend and level choice
  output logic usb_pwr_dn,
  output logic usb_pwr_up,
  output logic use_por_levels,
  // State report
  output logic [2:0] seq_state
);

  // --------------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------------
  pwsq_pkg::pwsq_regs_t s_r; // All state of the block
  pwsq_pkg::pwsq_regs_t s_nxt; // Next value

  logic [31:0] cur_cfg; // Config of the current state
  logic [4:0] cur_log; // Log2 dwell of current state
  logic dwell_done; // Minimum time expired
  logic tmr_match; // Timer wake hit
  logic pin_match; // Pin wake hit
  logic goods_ok; // All enabled supplies good
  logic wake_any; // Enabled wake condition
  logic [31:0] rd_word; // Read mux
  logic sleep_req; // Sleep request this cycle
  pwsq_pkg::pwsq_supply_t sup_cfg; // Supply outputs decoded from cur_cfg

  // --------------------------------------------------------------------------
  // Condition decode
  // --------------------------------------------------------------------------
  // Picks the config word of whatever state the walk stands in
  always_comb begin
    case (s_r.state)
      pwsq_pkg::sleep_entry_stage_one: begin
        cur_cfg = s_r.cfg_sleep1;
      end
      pwsq_pkg::sleep_entry_stage_two: begin
        cur_cfg = s_r.cfg_sleep2;
      end
      pwsq_pkg::dormant_state: begin
        cur_cfg = s_r.cfg_dormant;
      end
      pwsq_pkg::rouse_stage_one: begin
        cur_cfg = s_r.cfg_rouse1;
      end
      pwsq_pkg::rouse_stage_two: begin
        cur_cfg = s_r.cfg_rouse2;
      end
      default: begin
        cur_cfg = s_r.cfg_running;
      end
    endcase
  end

  // Wake, dwell and supply-good conditions
  always_comb begin
    cur_log = cur_cfg[`PWSQ_SUP_LOG_HI:`PWSQ_SUP_LOG_LO];
    // counted on this clock, the one currently enabled
    dwell_done = (s_r.dwell >= ((32'h0000_0001 << cur_log) - 32'h0000_0001));
    // width select, 32 or 64 bits
    if (s_r.mode[`PWSQ_MODE_TMR64]) begin
      tmr_match = (rtc_count >= {s_r.wake_hi, s_r.wake_lo});
    end else begin
      tmr_match = (rtc_count[31:0] >= s_r.wake_lo);
    end
    pin_match = (wake_pin == s_r.mode[`PWSQ_MODE_PIN_POL]);
    wake_any = (s_r.mode[`PWSQ_MODE_TMR_EN] & tmr_match) | (s_r.mode[`PWSQ_MODE_PIN_EN] & pin_match);
    // every enabled supply must report good
    goods_ok = (~cur_cfg[`PWSQ_SUP_IO_EN] | supply_good[3]) & (~cur_cfg[`PWSQ_SUP_PLL_EN] | supply_good[2])
             & (~cur_cfg[`PWSQ_SUP_ANA_EN] | supply_good[1]) & (~cur_cfg[`PWSQ_SUP_CORE_EN] | supply_good[0]);
    sleep_req = reg_wr & (reg_addr == `PWSQ_OFS_MODE) & reg_wdata[`PWSQ_MODE_SLEEP];
    sup_cfg.tile_clk_off = cur_cfg[`PWSQ_SUP_TILE_OFF];
    sup_cfg.analogue_buck_converter_pfm = cur_cfg[`PWSQ_SUP_ANA_PFM];
    sup_cfg.core_buck_converter_pfm = cur_cfg[`PWSQ_SUP_CORE_PFM];
    sup_cfg.io_supply_switch_en = cur_cfg[`PWSQ_SUP_IO_EN];
    sup_cfg.pll_supply_regulator_en = cur_cfg[`PWSQ_SUP_PLL_EN];
    sup_cfg.analogue_buck_converter_en = cur_cfg[`PWSQ_SUP_ANA_EN];
    sup_cfg.core_buck_converter_en = cur_cfg[`PWSQ_SUP_CORE_EN];
  end

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  // Self-clearing bits 1 and 6 read as zero; unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      `PWSQ_OFS_MODE: begin
        rd_word = s_r.mode;
      end
      `PWSQ_OFS_WAKE_LO: begin
        rd_word = s_r.wake_lo;
      end
      `PWSQ_OFS_WAKE_HI: begin
        rd_word = s_r.wake_hi;
      end
      `PWSQ_OFS_DORMANT: begin
        rd_word = s_r.cfg_dormant;
      end
      `PWSQ_OFS_ROUSE1: begin
        rd_word = s_r.cfg_rouse1;
      end
      `PWSQ_OFS_ROUSE2: begin
        rd_word = s_r.cfg_rouse2;
      end
      `PWSQ_OFS_RUNNING: begin
        rd_word = s_r.cfg_running;
      end
      `PWSQ_OFS_SLEEP1: begin
        rd_word = s_r.cfg_sleep1;
      end
      `PWSQ_OFS_SLEEP2: begin
        rd_word = s_r.cfg_sleep2;
      end
      `PWSQ_OFS_STATUS: begin
        rd_word = {29'h0000_0000, s_r.state};
      end
      `PWSQ_OFS_BUCK: begin
        rd_word = s_r.buck;
      end
      `PWSQ_OFS_GOOD: begin
        rd_word = {28'h000_0000, supply_good};
      end
      `PWSQ_OFS_CORE_LVL: begin
        rd_word = s_r.core_lvl;
      end
      `PWSQ_OFS_PLL_LVL: begin
        rd_word = s_r.pll_lvl;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  // Register writes, state walk and registered outputs
  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = reg_rd;
    s_nxt.rdata = reg_rd ? rd_word : s_r.rdata;
    if (reg_wr) begin
      case (reg_addr)
        `PWSQ_OFS_MODE: begin
          s_nxt.mode = reg_wdata & `PWSQ_MODE_WMASK;
        end
        `PWSQ_OFS_WAKE_LO: begin
          s_nxt.wake_lo = reg_wdata;
        end
        `PWSQ_OFS_WAKE_HI: begin
          s_nxt.wake_hi = reg_wdata;
        end
        // analogue enable left out of the write mask
        `PWSQ_OFS_DORMANT: begin
          s_nxt.cfg_dormant = (s_r.cfg_dormant & ~`PWSQ_SUP_WMASK) | (reg_wdata & `PWSQ_SUP_WMASK);
        end
        `PWSQ_OFS_ROUSE1: begin
          s_nxt.cfg_rouse1 = (s_r.cfg_rouse1 & ~`PWSQ_SUP_WMASK) | (reg_wdata & `PWSQ_SUP_WMASK);
        end
        `PWSQ_OFS_ROUSE2: begin
          s_nxt.cfg_rouse2 = (s_r.cfg_rouse2 & ~`PWSQ_SUP_WMASK) | (reg_wdata & `PWSQ_SUP_WMASK);
        end
        `PWSQ_OFS_RUNNING: begin
          s_nxt.cfg_running = (s_r.cfg_running & ~`PWSQ_RUN_WMASK) | (reg_wdata & `PWSQ_RUN_WMASK);
        end
        `PWSQ_OFS_SLEEP1: begin
          s_nxt.cfg_sleep1 = (s_r.cfg_sleep1 & ~`PWSQ_SUP_WMASK) | (reg_wdata & `PWSQ_SUP_WMASK);
        end
        `PWSQ_OFS_SLEEP2: begin
          s_nxt.cfg_sleep2 = (s_r.cfg_sleep2 & ~`PWSQ_SUP_WMASK) | (reg_wdata & `PWSQ_SUP_WMASK);
        end
        `PWSQ_OFS_BUCK: begin
          s_nxt.buck = reg_wdata;
        end
        `PWSQ_OFS_CORE_LVL: begin
          s_nxt.core_lvl = reg_wdata;
        end
        `PWSQ_OFS_PLL_LVL: begin
          s_nxt.pll_lvl = reg_wdata;
        end
        default: begin
          // Read-only or unmapped: write ignored
        end
      endcase
    end
    // Dwell counter advances every cycle in a state, saturating
    if (s_r.dwell != 32'hFFFF_FFFF) begin
      s_nxt.dwell = s_r.dwell + 32'h0000_0001;
    end
    case (s_r.state)
      pwsq_pkg::running_state: begin
        // requests outside the running state are simply not acted on
        if (sleep_req) begin
          s_nxt.state = pwsq_pkg::sleep_entry_stage_one;
          s_nxt.dwell = 32'h0000_0000;
        end
      end
      pwsq_pkg::sleep_entry_stage_one: begin
        if (dwell_done) begin
          s_nxt.state = pwsq_pkg::sleep_entry_stage_two;
          s_nxt.dwell = 32'h0000_0000;
        end
      end
      pwsq_pkg::sleep_entry_stage_two: begin
        if (dwell_done) begin
          s_nxt.state = pwsq_pkg::dormant_state;
          s_nxt.dwell = 32'h0000_0000;
        end
      end
      pwsq_pkg::dormant_state: begin
        // minimum time, then an enabled wake
        if (dwell_done && wake_any) begin
          s_nxt.state = pwsq_pkg::rouse_stage_one;
          s_nxt.dwell = 32'h0000_0000;
        end
      end
      pwsq_pkg::rouse_stage_one: begin
        if (dwell_done && goods_ok) begin
          s_nxt.state = pwsq_pkg::rouse_stage_two;
          s_nxt.dwell = 32'h0000_0000;
        end
      end
      pwsq_pkg::rouse_stage_two: begin
        if (dwell_done && goods_ok) begin
          s_nxt.state = pwsq_pkg::running_state;
          s_nxt.dwell = 32'h0000_0000;
        end
      end
      default: begin
        s_nxt.state = pwsq_pkg::running_state;
      end
    endcase
    s_nxt.mode[`PWSQ_MODE_SLEEP] = 1'b0;
    s_nxt.mode[`PWSQ_MODE_REAPPLY] = 1'b0;
    // supplies track current config each cycle, so the running word
    // is reapplied on the next edge whether or not the strobe is written
    s_nxt.supply = sup_cfg;
    // slow clock only while dormant and bit 0 is zero
    s_nxt.slow_clk_sel = (s_r.state == pwsq_pkg::dormant_state) & ~s_r.mode[`PWSQ_MODE_CLKSEL];
    s_nxt.usb_pwr_dn = s_r.mode[`PWSQ_MODE_USB_DN];
    s_nxt.usb_pwr_up = s_r.mode[`PWSQ_MODE_USB_UP];
    s_nxt.use_por_levels = s_r.mode[`PWSQ_MODE_PORLVL];
  end

  // --------------------------------------------------------------------------
  // State flops
  // --------------------------------------------------------------------------
  // Reset values are constants only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r.mode <= `PWSQ_MODE_RST;
      s_r.wake_lo <= `PWSQ_WORD_RST;
      s_r.wake_hi <= `PWSQ_WORD_RST;
      s_r.cfg_dormant <= `PWSQ_DORMANT_RST;
      s_r.cfg_rouse1 <= `PWSQ_ROUSE1_RST;
      s_r.cfg_rouse2 <= `PWSQ_ROUSE2_RST;
      s_r.cfg_running <= `PWSQ_RUNNING_RST;
      s_r.cfg_sleep1 <= `PWSQ_SLEEP_RST;
      s_r.cfg_sleep2 <= `PWSQ_SLEEP_RST;
      s_r.buck <= `PWSQ_WORD_RST;
      s_r.core_lvl <= `PWSQ_WORD_RST;
      s_r.pll_lvl <= `PWSQ_WORD_RST;
      s_r.state <= pwsq_pkg::running_state;
      s_r.dwell <= `PWSQ_WORD_RST;
      s_r.rdata <= `PWSQ_WORD_RST;
      s_r.rvalid <= 1'b0;
      s_r.supply <= `PWSQ_SUPPLY_RST;
      s_r.slow_clk_sel <= 1'b0;
      s_r.usb_pwr_dn <= 1'b0;
      s_r.usb_pwr_up <= 1'b0;
      s_r.use_por_levels <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, straight from flops
  // --------------------------------------------------------------------------
  assign reg_rdata = s_r.rdata;
  assign reg_rvalid = s_r.rvalid;
  assign core_buck_converter_en = s_r.supply.core_buck_converter_en;
  assign analogue_buck_converter_en = s_r.supply.analogue_buck_converter_en;
  assign pll_supply_regulator_en = s_r.supply.pll_supply_regulator_en;
  assign io_supply_switch_en = s_r.supply.io_supply_switch_en;
  assign core_buck_converter_pfm = s_r.supply.core_buck_converter_pfm;
  assign analogue_buck_converter_pfm = s_r.supply.analogue_buck_converter_pfm;
  assign tile_clk_off = s_r.supply.tile_clk_off;
  assign slow_clk_sel = s_r.slow_clk_sel;
  assign usb_pwr_dn = s_r.usb_pwr_dn;
  assign usb_pwr_up = s_r.usb_pwr_up;
  assign use_por_levels = s_r.use_por_levels;
  assign seq_state = s_r.state;

endmodule

`default_nettype wire

// ==== tb/pwsq_chk.sv ====
/*
  Assertion checker for the power sleep/wake sequencer.
  Assumes it is bound to pwsq_sequencer and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module pwsq_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register path
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  // Wake sources
  input wire logic [63:0] rtc_count,
  input wire logic wake_pin,
  // Observed controls and state
  input wire logic slow_clk_sel,
  input wire logic usb_pwr_dn,
  input wire logic usb_pwr_up,
  input wire logic use_por_levels,
  input wire logic [2:0] seq_state
);
  // ---------------------------------------------------------------
  // Shadow of mode and wake time
  // ---------------------------------------------------------------
  logic [31:0] mode_r; // Mode word as last written
  logic [63:0] wake_r; // Wake time as last written
  logic wake_c; // An enabled wake source is present
  // Taken from the write strobe so no design internals are needed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= 32'h0000_0008;
      wake_r <= 64'h0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h00) mode_r <= reg_wdata;
      if (reg_addr == 8'h04) wake_r[31:0] <= reg_wdata;
      if (reg_addr == 8'h08) wake_r[63:32] <= reg_wdata;
    end
  end
  assign wake_c = (mode_r[2] && (wake_pin == mode_r[3])) ||
    (mode_r[4] && (mode_r[5] ? rtc_count >= wake_r : rtc_count[31:0] >= wake_r[31:0]));
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_state_order: assert property (
    $changed(seq_state) |-> seq_state == (($past(seq_state) == 3'h5) ? 3'h0 : $past(seq_state) + 3'h1))
    else $error("state walk out of order");
  a_sleep_start: assert property (
    seq_state == 3'h0 && reg_wr && reg_addr == 8'h00 && reg_wdata[1] |=> seq_state == 3'h1)
    else $error("sleep request not taken");
  a_running_hold: assert property (
    seq_state == 3'h0 && !(reg_wr && reg_addr == 8'h00 && reg_wdata[1]) |=> seq_state == 3'h0)
    else $error("running state left without request");
  a_dormant_hold: assert property (
    seq_state == 3'h3 && !wake_c |=> seq_state == 3'h3)
    else $error("dormant state left without wake");
  a_slow_clock: assert property (
    slow_clk_sel == ($past(seq_state) == 3'h3 && !$past(mode_r[0])))
    else $error("sleep clock choice wrong");
  a_usb_copy: assert property (
    {usb_pwr_dn, usb_pwr_up, use_por_levels} == $past({mode_r[8], mode_r[9], mode_r[7]}))
    else $error("usb or level choice wrong");
  a_status_read: assert property (
    reg_rd && reg_addr == 8'h24 |=> reg_rvalid && reg_rdata[2:0] == $past(seq_state))
    else $error("status read wrong");
  a_mode_read: assert property (
    reg_rd && reg_addr == 8'h00 |=> reg_rvalid && !reg_rdata[1] && !reg_rdata[6] && reg_rdata[31:10] == 22'h0)
    else $error("mode read shows strobe bits");
  a_rvalid_cause: assert property (
    reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
endmodule
`default_nettype wire

// ==== tb/pwsq_env_model.sv ====
/*
  Model of the supplies and real-time counter around the sequencer.
  Assumes one free-running clock; the bench can hold supplies bad.
*/
`timescale 1ns/1ps
`default_nettype none
module pwsq_env_model #(
  parameter int GOOD_DLY = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Supply enables: io, pll, analogue, core
  input wire logic [3:0] supply_en,
  // Slow regulator: keeps every supply not good
  input wire logic hold_bad,
  // Answers to the sequencer
  output logic [63:0] rtc_count,
  output logic [3:0] supply_good
);
  logic [7:0] age_r [4]; // Cycles each supply has been on
  // Counter runs freely; supplies age while enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rtc_count <= 64'h0;
      for (int i = 0; i < 4; i++) age_r[i] <= 8'h00;
    end else begin
      rtc_count <= rtc_count + 64'h1;
      for (int i = 0; i < 4; i++) age_r[i] <= !supply_en[i] ? 8'h00 : age_r[i] + {7'h00, age_r[i] != 8'hFF};
    end
  end
  // good after settling
  // A supply switched off never reports good, so stale flags cannot pass
  always_comb begin
    for (int i = 0; i < 4; i++) supply_good[i] = !hold_bad && supply_en[i] && age_r[i] >= GOOD_DLY[7:0];
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
/*
  Self-checking bench for the power sleep/wake sequencer.
  Assumes the sequencer, its checker and the supply model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] rst;
    logic [31:0] exp;
  } pwsq_row_t;
  logic clk, rst_n, reg_wr, reg_rd, reg_rvalid, wake_pin, hold_bad;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, lo;
  logic [63:0] rtc_count;
  logic [3:0] supply_good;
  logic core_en, ana_en, pll_en, io_en, core_pfm, ana_pfm, tile_off, slow_sel, usb_dn, usb_up, por;
  logic [2:0] seq_state;
  int fail_count = 0;
  int tests_run = 0;
  int n, d;
  // Address, reset value, value read after writing FFFF_FFBD
  pwsq_row_t rows [14] = '{
    '{8'h00, 32'h0000_0008, 32'h0000_03BD}, '{8'h04, 32'h0, 32'hFFFF_FFBD}, '{8'h08, 32'h0, 32'hFFFF_FFBD},
    '{8'h0C, 32'h0010_0000, 32'h001F_4331}, '{8'h10, 32'h0010_0020, 32'h001F_4331},
    '{8'h14, 32'h0010_0033, 32'h001F_4333}, '{8'h18, 32'h0000_0033, 32'h0000_4333},
    '{8'h1C, 32'h0010_0033, 32'h001F_4333}, '{8'h20, 32'h0010_0033, 32'h001F_4333},
    '{8'h24, 32'h0, 32'h0}, '{8'h2C, 32'h0, 32'hFFFF_FFBD}, '{8'h34, 32'h0, 32'hFFFF_FFBD},
    '{8'h40, 32'h0, 32'hFFFF_FFBD}, '{8'h3C, 32'h0, 32'h0}};
  // Short walk: one cycle per stage, dormant 8 cycles with tile off and both converters in PFM
  logic [39:0] cfg [6] = '{40'h18_0000_0031, 40'h1C_0000_0033, 40'h20_0000_0011,
    40'h0C_0003_4301, 40'h10_0000_0031, 40'h14_0000_0031};
  pwsq_sequencer pwsq_sequencer_inst (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .rtc_count(rtc_count), .wake_pin(wake_pin), .supply_good(supply_good),
    .core_buck_converter_en(core_en), .analogue_buck_converter_en(ana_en), .pll_supply_regulator_en(pll_en),
    .io_supply_switch_en(io_en), .core_buck_converter_pfm(core_pfm), .analogue_buck_converter_pfm(ana_pfm),
    .tile_clk_off(tile_off), .slow_clk_sel(slow_sel), .usb_pwr_dn(usb_dn), .usb_pwr_up(usb_up),
    .use_por_levels(por), .seq_state(seq_state));
  pwsq_env_model pwsq_env_model_inst (.clk(clk), .rst_n(rst_n), .supply_en({io_en, pll_en, ana_en, core_en}),
    .hold_bad(hold_bad), .rtc_count(rtc_count), .supply_good(supply_good));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // Strobes last one cycle; the extra negedge keeps a gap between requests
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk({31'h0, reg_rvalid}, 32'h1);
    chk(reg_rdata, exp);
  endtask
  task automatic wait_state(input logic [2:0] s, input int lim);
    n = 0;
    while (seq_state !== s && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk({29'h0, seq_state}, {29'h0, s});
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Clock, watchdog and sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Whole run is under 2000 cycles
  initial begin
    #(5000 * 100);
    fail_count++;
    complete_run();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, wake_pin, hold_bad} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (4) @(negedge clk);
    chk({25'h0, seq_state, slow_sel, usb_dn, usb_up, reg_rvalid}, 32'h0);
    rst_n = 1'b1;
    // Reset values, masked write, read back
    for (int i = 0; i < 14; i++) begin
      rd(rows[i].addr, rows[i].rst);
      wr(rows[i].addr, 32'hFFFF_FFBD);
      rd(rows[i].addr, rows[i].exp);
    end
    chk({29'h0, usb_dn, usb_up, por}, 32'h7);
    wr(8'h00, 32'h0);
    @(negedge clk);
    chk({29'h0, usb_dn, usb_up, por}, 32'h0);
    for (int i = 0; i < 6; i++) wr(cfg[i][39:32], cfg[i][31:0]);
    // Pin wake on high, slow regulators during rouse
    wake_pin = 1'b1;
    hold_bad = 1'b1;
    wr(8'h00, 32'h0000_000E);
    chk({29'h0, seq_state}, 32'h1);
    rd(8'h00, 32'h0000_000C);
    wait_state(3'h3, 20);
    d = 0;
    while (seq_state === 3'h3 && d < 40) begin
      if (d == 2) chk({24'h0, tile_off, ana_pfm, core_pfm, io_en, pll_en, ana_en, core_en, slow_sel}, 32'hE3);
      @(negedge clk);
      d++;
    end
    chk({31'h0, d >= 8 && d <= 9}, 32'h1);
    repeat (20) @(negedge clk);
    chk({29'h0, seq_state}, 32'h4);
    hold_bad = 1'b0;
    wait_state(3'h0, 60);
    // Timer wake on the low word, high word ignored
    wake_pin = 1'b0;
    lo = rtc_count[31:0] + 32'd300;
    wr(8'h04, lo);
    wr(8'h08, 32'hFFFF_FFFF);
    wr(8'h00, 32'h0000_0013);
    wait_state(3'h3, 20);
    @(negedge clk);
    chk({31'h0, slow_sel}, 32'h0);
    rd(8'h24, 32'h3);
    wait_state(3'h4, 400);
    chk({31'h0, rtc_count[31:0] >= lo && rtc_count[31:0] <= lo + 32'd4}, 32'h1);
    wait_state(3'h0, 60);
    // Full width compare holds off the timer; pin wakes on low
    wake_pin = 1'b1;
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h0000_0037);
    wait_state(3'h3, 20);
    repeat (50) @(negedge clk);
    chk({29'h0, seq_state}, 32'h3);
    wake_pin = 1'b0;
    wait_state(3'h4, 4);
    wait_state(3'h0, 60);
    // Reapply running settings
    wr(8'h18, 32'h0000_4031);
    wr(8'h00, 32'h0000_0040);
    rd(8'h00, 32'h0);
    chk({31'h0, tile_off}, 32'h1);
    // All four supplies enabled long enough to report good
    rd(8'h30, 32'h0000_000F);
    complete_run();
  end
endmodule
bind pwsq_sequencer pwsq_chk pwsq_chk_inst (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .rtc_count(rtc_count), .wake_pin(wake_pin), .slow_clk_sel(slow_clk_sel), .usb_pwr_dn(usb_pwr_dn),
  .usb_pwr_up(usb_pwr_up), .use_por_levels(use_por_levels), .seq_state(seq_state));
`default_nettype wire
